// >>> hw/mbws_pkg.sv
// constants and types shared by the single-parameter write handler
package mbws_pkg;

  // ************************************************************
  // clock and line timing
  // ************************************************************
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned BAUD_DEFAULT  = 9600;
  localparam int unsigned BITS_PER_CHAR = 11;
  // silent gap, in tenths of a character time (3.5 chars)
  localparam int unsigned GAP_CHARS_X10 = 35;
  // product passes 2^31, so it is formed in 64 bits
  localparam longint unsigned GAP_NUM =
    longint'(CLK_HZ) * BITS_PER_CHAR * GAP_CHARS_X10;
  localparam longint unsigned GAP_DEN = longint'(BAUD_DEFAULT) * 10;
  // least time: round up
  localparam int unsigned GAP_CYCLES_DEFAULT =
    int'((GAP_NUM + GAP_DEN - 1) / GAP_DEN);
  // wait for the parameter store before giving up
  localparam int unsigned ACK_TIMEOUT_DEFAULT = 1024;

  // ************************************************************
  // frame layout
  // ************************************************************
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [3:0] FRAME_LEN   = 4'h8;
  localparam logic [3:0] IDX_ADDR    = 4'h0;
  localparam logic [3:0] IDX_FUNC    = 4'h1;
  localparam logic [3:0] IDX_GROUP   = 4'h2;
  localparam logic [3:0] IDX_OFFSET  = 4'h3;
  localparam logic [3:0] IDX_VAL_HI  = 4'h4;
  localparam logic [3:0] IDX_VAL_LO  = 4'h5;
  localparam logic [3:0] IDX_CHK_LO  = 4'h6;
  localparam logic [3:0] IDX_CHK_HI  = 4'h7;

  localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] AXIS_MIN          = 8'h01;
  localparam logic [7:0] AXIS_MAX          = 8'hf7;

  // ************************************************************
  // check sequence
  // ************************************************************
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_HUNT,
    ST_RECV,
    ST_CHECK,
    ST_WRITE,
    ST_ECHO
  } mbws_state_type;

endpackage

// >>> hw/mbws_crc16.sv
// running crc-16 accumulator, reflected, one byte per step
`timescale 1ns/1ps
`default_nettype none
module mbws_crc16 (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // control
  input  wire logic        clear,
  input  wire logic        step,
  input  wire logic [7:0]  data_in,
  // result
  output logic      [15:0] crc_q
);

  // ************************************************************
  // one byte through the polynomial, lsb first
  // ************************************************************
  function automatic logic [15:0] crc_next(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ mbws_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // clear wins over step so a fresh frame never inherits old state
  always_ff @(posedge clk) begin
    if (!resetn || clear) begin
      crc_q <= mbws_pkg::CRC_INIT;
    end else if (step) begin
      crc_q <= crc_next(crc_q, data_in);
    end
  end

endmodule
`default_nettype wire

// >>> hw/mbws_fifo.sv
// small fifo with registered read data, valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module mbws_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             load;

  // full means no room in the array; the output stage is extra
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign load     = (cnt_q != '0) && (!out_valid || out_ready);

  // storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (load) rd_ptr_q <= rd_ptr_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // registered read data
  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> hw/mbws_top.sv
// write-single-parameter frame handler: receive, check, write, echo
`timescale 1ns/1ps
`default_nettype none
module mbws_top #(
  parameter int unsigned GAP_CYCLES  = mbws_pkg::GAP_CYCLES_DEFAULT,
  parameter int unsigned ACK_TIMEOUT = mbws_pkg::ACK_TIMEOUT_DEFAULT,
  parameter int unsigned FIFO_DEPTH  = mbws_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // receive characters from the serial layer
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_error,
  // transmit characters to the serial layer
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,
  // own axis address
  input  wire logic [7:0]  axis_addr,
  // parameter store
  output logic             param_wr,
  output logic      [15:0] param_addr,
  output logic      [15:0] param_data,
  input  wire logic        param_ack,
  input  wire logic        param_reject,
  // frame status
  output logic             frame_ok,
  output logic             frame_drop
);

  // ************************************************************
  // configuration checks
  // ************************************************************
  localparam int unsigned GW = $clog2(GAP_CYCLES + 1);
  localparam int unsigned TW = $clog2(ACK_TIMEOUT + 1);

  if (GAP_CYCLES < 1 || ACK_TIMEOUT < 1) begin : g_bad_time
    $error("gap and timeout counts must be at least one cycle");
  end
  if (FIFO_DEPTH < 32'(mbws_pkg::FRAME_LEN)) begin : g_bad_fifo
    $error("fifo must hold a whole reply frame");
  end

  // ************************************************************
  // declarations
  // ************************************************************
  mbws_pkg::mbws_state_type state_q;

  logic [GW-1:0] idle_cnt_q;
  logic          gap_seen;
  logic [7:0]    frame_q [8];
  logic [3:0]    rx_cnt_q;
  logic          bad_q;
  logic          take;
  logic [15:0]   crc_rx;
  logic [15:0]   crc_tx;
  logic          frame_good;
  logic [TW-1:0] tmo_q;
  logic          tmo_hit;
  logic [3:0]    tx_idx_q;
  logic [7:0]    echo_byte;
  logic          echo_valid;
  logic          echo_ready;
  logic          echo_push;
  logic          echo_last;
  logic          wr_d;
  logic          ok_d;
  logic          drop_d;

  // ************************************************************
  // frame delimiting by line silence
  // ************************************************************

  // cycles since the last character, saturating at the gap
  always_ff @(posedge clk) begin
    if (!resetn) begin
      idle_cnt_q <= '0; // after reset the line counts as busy
    end else if (rx_valid) begin
      idle_cnt_q <= '0;
    end else if (idle_cnt_q != GW'(GAP_CYCLES)) begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  assign gap_seen = (idle_cnt_q == GW'(GAP_CYCLES));

  // ************************************************************
  // receive buffer
  // ************************************************************

  // characters are only taken once a leading gap was seen
  assign take = rx_valid && (state_q == mbws_pkg::ST_RECV);

  // byte count; stops at frame length, extras mark the frame bad
  always_ff @(posedge clk) begin
    if (!resetn || state_q == mbws_pkg::ST_HUNT) begin
      rx_cnt_q <= '0;
    end else if (take && rx_cnt_q != mbws_pkg::FRAME_LEN) begin
      rx_cnt_q <= rx_cnt_q + 1'b1;
    end
  end

  // overlong frame or character error spoils the whole frame
  always_ff @(posedge clk) begin
    if (!resetn || state_q == mbws_pkg::ST_HUNT) begin
      bad_q <= 1'b0;
    end else if (take && (rx_error || rx_cnt_q == mbws_pkg::FRAME_LEN)) begin
      bad_q <= 1'b1;
    end
  end

  // frame bytes, addressed by arrival order
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        frame_q[i] <= '0;
      end
    end else if (take && rx_cnt_q != mbws_pkg::FRAME_LEN) begin
      frame_q[rx_cnt_q[2:0]] <= rx_data;
    end
  end

  // ************************************************************
  // check sequences
  // ************************************************************

  // running over all bytes incl. check bytes leaves a zero residue
  mbws_crc16 u_crc_rx (
    .clk     (clk),
    .resetn  (resetn),
    .clear   (state_q == mbws_pkg::ST_HUNT),
    .step    (take),
    .data_in (rx_data),
    .crc_q   (crc_rx)
  );

  // reply check value is computed anew from the echoed bytes
  mbws_crc16 u_crc_tx (
    .clk     (clk),
    .resetn  (resetn),
    .clear   (state_q != mbws_pkg::ST_ECHO),
    .step    (echo_push && tx_idx_q < mbws_pkg::IDX_CHK_LO),
    .data_in (echo_byte),
    .crc_q   (crc_tx)
  );

  // ************************************************************
  // frame acceptance
  // ************************************************************

  // exact length, good check, own valid address, right function
  assign frame_good =
    !bad_q &&
    rx_cnt_q == mbws_pkg::FRAME_LEN &&
    crc_rx == mbws_pkg::CRC_RESIDUE &&
    axis_addr >= mbws_pkg::AXIS_MIN &&
    axis_addr <= mbws_pkg::AXIS_MAX &&
    frame_q[mbws_pkg::IDX_ADDR[2:0]] == axis_addr &&
    frame_q[mbws_pkg::IDX_FUNC[2:0]] ==
      mbws_pkg::FUNC_WRITE_SINGLE;

  // ************************************************************
  // parameter store handshake
  // ************************************************************

  // bounded wait so a silent store cannot hang the handler
  always_ff @(posedge clk) begin
    if (!resetn || state_q != mbws_pkg::ST_WRITE) begin
      tmo_q <= '0;
    end else if (tmo_q != TW'(ACK_TIMEOUT)) begin
      tmo_q <= tmo_q + 1'b1;
    end
  end

  assign tmo_hit = (tmo_q == TW'(ACK_TIMEOUT));

  // a rejected write (e.g. 32-bit target) gets no echo
  assign wr_d = (state_q == mbws_pkg::ST_CHECK) && frame_good;

  // write strobe and its address/value, all registered
  always_ff @(posedge clk) begin
    if (!resetn) begin
      param_wr   <= 1'b0;
      param_addr <= '0;
      param_data <= '0;
    end else begin
      param_wr <= wr_d;
      if (wr_d) begin
        param_addr <= {frame_q[mbws_pkg::IDX_GROUP[2:0]],
                       frame_q[mbws_pkg::IDX_OFFSET[2:0]]};
        param_data <= {frame_q[mbws_pkg::IDX_VAL_HI[2:0]],
                       frame_q[mbws_pkg::IDX_VAL_LO[2:0]]};
      end
    end
  end

  // ************************************************************
  // echo generation
  // ************************************************************

  // copied bytes first, then the new check value low then high
  always_comb begin
    if (tx_idx_q == mbws_pkg::IDX_CHK_LO) begin
      echo_byte = crc_tx[7:0];
    end else if (tx_idx_q == mbws_pkg::IDX_CHK_HI) begin
      echo_byte = crc_tx[15:8];
    end else begin
      echo_byte = frame_q[tx_idx_q[2:0]];
    end
  end

  assign echo_valid = (state_q == mbws_pkg::ST_ECHO);
  assign echo_push  = echo_valid && echo_ready;
  assign echo_last  = echo_push && tx_idx_q == mbws_pkg::IDX_CHK_HI;

  // position in the reply
  always_ff @(posedge clk) begin
    if (!resetn || state_q != mbws_pkg::ST_ECHO) begin
      tx_idx_q <= '0;
    end else if (echo_push) begin
      tx_idx_q <= tx_idx_q + 1'b1;
    end
  end

  // reply buffer; a stalled serial layer holds the echo back
  mbws_fifo #(
    .WIDTH (mbws_pkg::BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (echo_valid),
    .in_data   (echo_byte),
    .in_ready  (echo_ready),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_ready)
  );

  // ************************************************************
  // sequencer
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= mbws_pkg::ST_HUNT;
    end else begin
      case (state_q)
        // wait for a clean leading gap before listening
        mbws_pkg::ST_HUNT: begin
          if (gap_seen) state_q <= mbws_pkg::ST_RECV;
        end
        // trailing gap closes a non-empty frame
        mbws_pkg::ST_RECV: begin
          if (gap_seen && rx_cnt_q != '0) begin
            state_q <= mbws_pkg::ST_CHECK;
          end
        end
        // foreign or damaged frames are dropped silently
        mbws_pkg::ST_CHECK: begin
          state_q <= frame_good ? mbws_pkg::ST_WRITE
                                : mbws_pkg::ST_HUNT;
        end
        // reply waits for the store to confirm the update
        mbws_pkg::ST_WRITE: begin
          if (param_ack) begin
            state_q <= mbws_pkg::ST_ECHO;
          end else if (param_reject || tmo_hit) begin
            state_q <= mbws_pkg::ST_HUNT;
          end
        end
        mbws_pkg::ST_ECHO: begin
          if (echo_last) state_q <= mbws_pkg::ST_HUNT;
        end
        default: begin
          state_q <= mbws_pkg::ST_HUNT;
        end
      endcase
    end
  end

  // ************************************************************
  // status pulses
  // ************************************************************
  assign ok_d   = echo_last;
  assign drop_d = ((state_q == mbws_pkg::ST_CHECK) && !frame_good) ||
                  ((state_q == mbws_pkg::ST_WRITE) && !param_ack &&
                   (param_reject || tmo_hit));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      frame_ok   <= 1'b0;
      frame_drop <= 1'b0;
    end else begin
      frame_ok   <= ok_d;
      frame_drop <= drop_d;
    end
  end

endmodule
`default_nettype wire

// >>> sim/mbws_top_assertions.sv
// concurrent checks on the write-single-parameter handler ports
`timescale 1ns/1ps
`default_nettype none
module mbws_top_assertions #(
  parameter int unsigned GAP_CYCLES = 12
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // receive side
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_error,
  // transmit side
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready,
  // own address and parameter store
  input wire logic [7:0]  axis_addr,
  input wire logic        param_wr,
  input wire logic [15:0] param_addr,
  input wire logic [15:0] param_data,
  input wire logic        param_ack,
  input wire logic        param_reject,
  // frame status
  input wire logic        frame_ok,
  input wire logic        frame_drop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ************************************************************
  // helpers
  // ************************************************************
  int unsigned idle_q;
  // cycles since the last character, the frame end is judged from it
  always_ff @(posedge clk) begin
    if (!resetn || rx_valid) begin
      idle_q <= 0;
    end else begin
      idle_q <= idle_q + 1;
    end
  end
  sequence wr_acked_s;
    param_wr ##[0:3] param_ack;
  endsequence
  sequence wr_refused_s;
    param_wr ##[0:3] param_reject;
  endsequence
  // a write lasts one cycle only
  wr_pulse_a: assert property (param_wr |=> !param_wr)
    else $error("store write longer than one cycle");
  // address and value move only with a write
  addr_hold_a: assert property (!param_wr |-> $stable(param_addr) && $stable(param_data))
    else $error("store address or value moved without a write");
  // a stalled reply byte must not change under the line
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte changed while stalled");
  // the whole echo is queued a fixed time after the update
  ok_timing_a: assert property (wr_acked_s |-> ##9 frame_ok)
    else $error("echo not queued nine cycles after update");
  // no echo without a preceding update
  ok_cause_a: assert property (frame_ok |-> $past(param_ack, 9))
    else $error("echo without store update");
  // a refused write is dropped and never echoed
  reject_drop_a: assert property (wr_refused_s |-> ##[1:2] (frame_drop ##1 !frame_ok [*8]))
    else $error("refused write not dropped");
  // the write comes only after the trailing silent gap
  gap_end_a: assert property (param_wr |-> idle_q inside {[GAP_CYCLES+1:GAP_CYCLES+3]})
    else $error("write not timed by the trailing gap");
  // status flags are single pulses and neither comes in the cycle right after a flag
  flag_excl_a: assert property (frame_ok || frame_drop |=> !frame_ok && !frame_drop)
    else $error("status flags overlap or stretch");
endmodule
bind mbws_top mbws_top_assertions #(.GAP_CYCLES(GAP_CYCLES)) mbws_top_assertions_i (
  .clk(clk), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data),
  .rx_error(rx_error), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
  .axis_addr(axis_addr), .param_wr(param_wr), .param_addr(param_addr),
  .param_data(param_data), .param_ack(param_ack), .param_reject(param_reject),
  .frame_ok(frame_ok), .frame_drop(frame_drop)
);
`default_nettype wire

// >>> sim/mbws_store_model.sv
// parameter store stand-in: answers each write after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module mbws_store_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // behaviour set by the bench
  input  wire logic [3:0] ack_delay,
  input  wire logic       refuse,
  // store port
  input  wire logic       param_wr,
  output logic            param_ack,
  output logic            param_reject
);
  logic       busy_q;
  logic [3:0] wait_q;
  // one write outstanding; a long delay exercises the slow store
  always_ff @(posedge clk) begin
    param_ack    <= 1'b0;
    param_reject <= 1'b0;
    if (!resetn) begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
    end else if (param_wr) begin
      busy_q <= 1'b1;
      wait_q <= ack_delay;
    end else if (busy_q) begin
      if (wait_q == 4'h0) begin
        busy_q       <= 1'b0;
        param_ack    <= !refuse; // value stored before the answer
        param_reject <= refuse;  // wide target refuses this command
      end else begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the write-single-parameter handler
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned GAP = 12;
  logic        clk, resetn, rx_valid, rx_error, tx_valid, tx_ready;
  logic        param_wr, param_ack, param_reject, frame_ok, frame_drop, refuse;
  logic [7:0]  rx_data, tx_data, axis_addr;
  logic [15:0] param_addr, param_data, wr_addr, wr_data;
  logic [3:0]  ack_delay;
  logic [7:0]  got_q[$], exp_q[$];
  int          error_cnt = 0, checks = 0, ok_n = 0, drop_n = 0, wr_n = 0;
  int          b_ok, b_dr, b_wr;
  mbws_top #(.GAP_CYCLES(GAP), .ACK_TIMEOUT(16), .FIFO_DEPTH(16)) mbws_top_i (
    .clk(clk), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_error(rx_error), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .axis_addr(axis_addr), .param_wr(param_wr), .param_addr(param_addr),
    .param_data(param_data), .param_ack(param_ack), .param_reject(param_reject),
    .frame_ok(frame_ok), .frame_drop(frame_drop));
  mbws_store_model mbws_store_model_i (
    .clk(clk), .resetn(resetn), .ack_delay(ack_delay), .refuse(refuse),
    .param_wr(param_wr), .param_ack(param_ack), .param_reject(param_reject));
  // ************************************************************
  // monitors and helpers
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // record what reaches the line and the store
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got_q.push_back(tx_data);
    if (param_wr === 1'b1) begin
      wr_n++;
      wr_addr = param_addr;
      wr_data = param_data;
    end
    if (frame_ok === 1'b1) ok_n++;
    if (frame_drop === 1'b1) drop_n++;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // reflected crc over address..data, written apart from the design
  function automatic logic [15:0] crc_of(input logic [47:0] body);
    logic [15:0] c;
    c = mbws_pkg::CRC_INIT;
    for (int i = 0; i < 6; i++) begin
      c = c ^ {8'h00, body[47-8*i -: 8]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ mbws_pkg::CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  // one frame in, then wait for its verdict and a full silent gap
  task automatic send(input logic [47:0] body, input int n, input logic [15:0] flip,
                      input logic reply);
    logic [63:0] fr;
    logic [15:0] c;
    int          t;
    c  = crc_of(body) ^ flip;
    fr = {body, c[7:0], c[15:8]}; // check low byte goes first
    t  = ok_n + drop_n;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data  = fr[63-8*i -: 8];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    if (reply) for (int i = 0; i < 8; i++) exp_q.push_back(fr[63-8*i -: 8]);
    for (int i = 0; i < 400 && ok_n + drop_n == t; i++) @(negedge clk);
    if (ok_n + drop_n == t) begin
      chk(32'(t), 32'(t + 1));
      end_of_test();
    end
    repeat (GAP + 4) @(negedge clk);
  endtask
  task automatic mark();
    b_ok = ok_n;
    b_dr = drop_n;
    b_wr = wr_n;
  endtask
  task automatic outcome(input int d_ok, input int d_dr, input int d_wr);
    chk(32'(ok_n - b_ok), 32'(d_ok));
    chk(32'(drop_n - b_dr), 32'(d_dr));
    chk(32'(wr_n - b_wr), 32'(d_wr));
  endtask
  // the line stalls every other cycle while queued replies leave
  task automatic drain();
    for (int i = 0; i < 200 && got_q.size() < exp_q.size(); i++) begin
      @(negedge clk);
      tx_ready = ~tx_ready;
    end
    @(negedge clk);
    tx_ready = 1'b1;
    chk(32'(got_q.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) if (i < got_q.size()) chk(32'(got_q[i]), 32'(exp_q[i]));
    got_q.delete();
    exp_q.delete();
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  // two writes held back queue 16 reply bytes in the fifo without filling it, then both echoes drain
  task automatic sc_pair();
    mark();
    tx_ready = 1'b0;
    send(48'h01_06_02_02_00_01, 8, 16'h0000, 1'b1);
    chk({wr_addr, wr_data}, 32'h0202_0001);
    send(48'h01_06_06_11_ab_cd, 8, 16'h0000, 1'b1);
    chk({wr_addr, wr_data}, 32'h0611_abcd);
    outcome(2, 0, 2);
    drain();
  endtask
  // another axis: nothing written, nothing sent
  task automatic sc_foreign();
    mark();
    send(48'h02_06_02_02_00_01, 8, 16'h0000, 1'b0);
    outcome(0, 1, 0);
    drain();
  endtask
  // spoiled check bytes are discarded silently
  task automatic sc_bad_check();
    mark();
    send(48'h01_06_02_02_00_01, 8, 16'h0100, 1'b0);
    outcome(0, 1, 0);
    drain();
  endtask
  // the wide write code is not this handler's command
  task automatic sc_bad_func();
    mark();
    send(48'h01_10_02_02_00_01, 8, 16'h0000, 1'b0);
    outcome(0, 1, 0);
    drain();
  endtask
  // a frame cut short by the gap is dropped
  task automatic sc_short();
    mark();
    send(48'h01_06_02_02_00_01, 7, 16'h0000, 1'b0);
    outcome(0, 1, 0);
    drain();
  endtask
  // every character flagged bad spoils the frame
  task automatic sc_char_err();
    mark();
    rx_error = 1'b1;
    send(48'h01_06_02_02_00_01, 8, 16'h0000, 1'b0);
    rx_error = 1'b0;
    outcome(0, 1, 0);
  endtask
  // store refuses: write attempted, but no echo
  task automatic sc_reject();
    mark();
    refuse = 1'b1;
    send(48'h01_06_05_07_00_01, 8, 16'h0000, 1'b0);
    refuse = 1'b0;
    outcome(0, 1, 1);
    drain();
  endtask
  // store answers one cycle past the wait limit: dropped, no echo
  task automatic sc_timeout();
    ack_delay = 4'hf; // late answer must be ignored
    mark();
    send(48'h01_06_03_04_12_34, 8, 16'h0000, 1'b0);
    ack_delay = 4'h0;
    chk({wr_addr, wr_data}, 32'h0304_1234);
    outcome(0, 1, 1);
    drain();
  endtask
  // top axis value and a slow store still give a correct echo
  task automatic sc_slow();
    axis_addr = 8'hf7;
    ack_delay = 4'h7;
    mark();
    send(48'hf7_06_00_ff_80_00, 8, 16'h0000, 1'b1);
    chk({wr_addr, wr_data}, 32'h00ff_8000);
    outcome(1, 0, 1);
    drain();
  endtask
  initial begin
    resetn    = 1'b0;
    rx_valid  = 1'b0;
    rx_data   = 8'h00;
    rx_error  = 1'b0;
    tx_ready  = 1'b1;
    axis_addr = 8'h01;
    ack_delay = 4'h0;
    refuse    = 1'b0;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    repeat (GAP + 4) @(negedge clk);
    sc_pair();
    sc_foreign();
    sc_bad_check();
    sc_bad_func();
    sc_short();
    sc_char_err();
    sc_reject();
    sc_timeout();
    sc_slow();
    end_of_test();
  end
endmodule
`default_nettype wire
